// ### src/rpel_pkg.sv
`default_nettype none
package rpel_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_PAIR = 5;

  // Status and mask slot indices within the paired register arrays.
  localparam int unsigned IDX_UNC   = 0;
  localparam int unsigned IDX_COR   = 1;
  localparam int unsigned IDX_ROOT  = 2;
  localparam int unsigned IDX_P_COR = 3;
  localparam int unsigned IDX_P_UNC = 4;

  localparam logic [ADDR_W-1:0] OFS_SLOT_CTRL = 12'h0a8;
  localparam logic [ADDR_W-1:0] OFS_HDR_CAP   = 12'h11c;

  localparam logic [ADDR_W-1:0] OFS_STS  [NUM_PAIR] = '{12'h104, 12'h110, 12'h130,
                                                        12'h200, 12'h208};
  localparam logic [ADDR_W-1:0] OFS_MASK [NUM_PAIR] = '{12'h218, 12'h21c, 12'h220,
                                                        12'h228, 12'h224};

  localparam logic [DATA_W-1:0] MASK_RST      = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] STS_RST       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] HDR_RST       = 32'h0000_0000;
  localparam logic [15:0]       SLOT_CTRL_RST = 16'h0400;

  localparam int unsigned BIT_SURPRISE_DOWN = 5;
  localparam int unsigned BIT_MALFORMED     = 18;
  localparam int unsigned BIT_PWR_CTRL      = 10;
endpackage : rpel_pkg
`default_nettype wire

// ### src/rpel_root_port_err.sv
`timescale 1ns/1ps
`default_nettype none
module rpel_root_port_err (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_n,
  input  wire logic [rpel_pkg::ADDR_W-1:0] i_cfg_addr,
  input  wire logic                        i_cfg_wr,
  input  wire logic                        i_cfg_rd,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_cfg_wdata,
  output logic      [rpel_pkg::DATA_W-1:0] o_cfg_rdata,
  output logic                             o_cfg_ack,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_unc_err,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_cor_err,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_root_err,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_port_cor_err,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_port_unc_err,
  input  wire logic                        i_surprise_down,
  input  wire logic                        i_malformed_tlp,
  input  wire logic [rpel_pkg::DATA_W-1:0] i_tlp_header,
  output logic                             o_err_report,
  output logic                             o_pwr_ctrl
);
  localparam int unsigned NP = rpel_pkg::NUM_PAIR;
  localparam int unsigned DW = rpel_pkg::DATA_W;

  logic [DW-1:0] sts_r   [NP];
  logic [DW-1:0] mask_r  [NP];
  logic [DW-1:0] ev      [NP];
  logic [DW-1:0] ev_kept [NP];
  logic [DW-1:0] w1c     [NP];
  logic [DW-1:0] pending [NP];
  logic [NP-1:0] sts_hit;
  logic [NP-1:0] mask_hit;
  logic [NP-1:0] pend_any;
  logic [15:0]   slot_ctrl_r;
  logic [DW-1:0] hdr_r;
  logic [DW-1:0] rdata_nxt;
  logic          slot_hit;
  logic          hdr_hit;
  logic          sdown_ok;
  logic          mal_capture;
  logic [DW-1:0] sdown_vec;
  logic [DW-1:0] mal_vec;

  assign slot_hit = (i_cfg_addr == rpel_pkg::OFS_SLOT_CTRL);
  assign hdr_hit  = (i_cfg_addr == rpel_pkg::OFS_HDR_CAP);

  // Surprise down is only recorded while the power controller bit is clear.
  assign sdown_ok  = i_surprise_down && !slot_ctrl_r[rpel_pkg::BIT_PWR_CTRL];
  assign sdown_vec = DW'(sdown_ok) << rpel_pkg::BIT_SURPRISE_DOWN;
  assign mal_vec   = DW'(i_malformed_tlp) << rpel_pkg::BIT_MALFORMED;

  // The header is kept for an unmasked malformed packet only while its status flag is clear.
  assign mal_capture = i_malformed_tlp
                     && !mask_r[rpel_pkg::IDX_UNC][rpel_pkg::BIT_MALFORMED]
                     && !sts_r[rpel_pkg::IDX_UNC][rpel_pkg::BIT_MALFORMED];

  assign ev[rpel_pkg::IDX_UNC]   = i_unc_err | sdown_vec | mal_vec;
  assign ev[rpel_pkg::IDX_COR]   = i_cor_err;
  assign ev[rpel_pkg::IDX_ROOT]  = i_root_err;
  assign ev[rpel_pkg::IDX_P_COR] = i_port_cor_err;
  assign ev[rpel_pkg::IDX_P_UNC] = i_port_unc_err;

  genvar k;
  generate
    for (k = 0; k < NP; k++) begin : g_pair
      assign sts_hit[k]  = (i_cfg_addr == rpel_pkg::OFS_STS[k]);
      assign mask_hit[k] = (i_cfg_addr == rpel_pkg::OFS_MASK[k]);
      assign w1c[k]      = (i_cfg_wr && sts_hit[k]) ? i_cfg_wdata : '0;
      assign pending[k]  = sts_r[k] & ~mask_r[k];
      assign pend_any[k] = |pending[k];
      assign ev_kept[k]  = ev[k] & ~mask_r[k];

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          sts_r[k]  <= rpel_pkg::STS_RST;
          mask_r[k] <= rpel_pkg::MASK_RST;
        end else begin
          // A new event wins over a clear written in the same cycle.
          sts_r[k] <= (sts_r[k] & ~w1c[k]) | ev_kept[k];
          if (i_cfg_wr && mask_hit[k]) begin
            mask_r[k] <= i_cfg_wdata;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_nxt = '0;
    for (int i = 0; i < NP; i++) begin
      if (sts_hit[i]) begin
        rdata_nxt = sts_r[i];
      end
      if (mask_hit[i]) begin
        rdata_nxt = mask_r[i];
      end
    end
    if (slot_hit) begin
      rdata_nxt = {16'h0000, slot_ctrl_r};
    end
    if (hdr_hit) begin
      rdata_nxt = hdr_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      slot_ctrl_r  <= rpel_pkg::SLOT_CTRL_RST;
      hdr_r        <= rpel_pkg::HDR_RST;
      o_cfg_rdata  <= '0;
      o_cfg_ack    <= 1'b0;
      o_err_report <= 1'b0;
      o_pwr_ctrl   <= 1'b0;
    end else begin
      if (i_cfg_wr && slot_hit) begin
        slot_ctrl_r <= i_cfg_wdata[15:0];
      end
      if (mal_capture) begin
        hdr_r <= i_tlp_header;
      end
      o_cfg_rdata  <= i_cfg_rd ? rdata_nxt : '0;
      o_cfg_ack    <= i_cfg_rd || i_cfg_wr;
      o_err_report <= |pend_any;
      o_pwr_ctrl   <= slot_ctrl_r[rpel_pkg::BIT_PWR_CTRL];
    end
  end

  // Checks on the logging behaviour.
  localparam int unsigned UNC  = rpel_pkg::IDX_UNC;
  localparam int unsigned COR  = rpel_pkg::IDX_COR;
  localparam int unsigned ROOT = rpel_pkg::IDX_ROOT;
  localparam int unsigned PCOR = rpel_pkg::IDX_P_COR;
  localparam int unsigned PUNC = rpel_pkg::IDX_P_UNC;
  localparam int unsigned SDB  = rpel_pkg::BIT_SURPRISE_DOWN;
  localparam int unsigned MALB = rpel_pkg::BIT_MALFORMED;
  localparam int unsigned PWRB = rpel_pkg::BIT_PWR_CTRL;

  // Reset values are checked with no disable, so the reset branch itself is covered.
  a_reset_masks_one: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> (mask_r[UNC] == '1) && (mask_r[COR] == '1) && (mask_r[ROOT] == '1)
                 && (mask_r[PCOR] == '1) && (mask_r[PUNC] == '1))
    else $error("mask not all ones after reset");

  a_reset_sts_clear: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> (sts_r[UNC] == rpel_pkg::STS_RST) && (sts_r[COR] == rpel_pkg::STS_RST)
                 && (sts_r[ROOT] == rpel_pkg::STS_RST) && (sts_r[PCOR] == rpel_pkg::STS_RST)
                 && (sts_r[PUNC] == rpel_pkg::STS_RST))
    else $error("status not clear after reset");

  a_reset_slot_ctrl: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> (slot_ctrl_r == rpel_pkg::SLOT_CTRL_RST) && (hdr_r == rpel_pkg::HDR_RST))
    else $error("slot control or header not at reset value");

  a_reset_outputs: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> !o_cfg_ack && !o_err_report && !o_pwr_ctrl && (o_cfg_rdata == '0))
    else $error("outputs not idle after reset");

  a_unmasked_event_logs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cor_err != '0)
    |=> ((sts_r[COR] & $past(ev_kept[COR])) == $past(ev_kept[COR])))
    else $error("unmasked correctable event not logged");

  a_unc_mask_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> ((sts_r[UNC] & ~$past(sts_r[UNC]) & $past(mask_r[UNC])) == '0))
    else $error("masked uncorrectable bit recorded");

  a_cor_mask_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> ((sts_r[COR] & ~$past(sts_r[COR]) & $past(mask_r[COR])) == '0))
    else $error("masked correctable bit recorded");

  a_root_mask_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> ((sts_r[ROOT] & ~$past(sts_r[ROOT]) & $past(mask_r[ROOT])) == '0))
    else $error("masked root error bit recorded");

  a_port_mask_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> ((sts_r[PCOR] & ~$past(sts_r[PCOR]) & $past(mask_r[PCOR])) == '0)
             && ((sts_r[PUNC] & ~$past(sts_r[PUNC]) & $past(mask_r[PUNC])) == '0))
    else $error("masked port specific bit recorded");

  // Surprise down only counts while the power controller bit is clear.
  a_sdown_pwr_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_surprise_down && slot_ctrl_r[PWRB] && !sts_r[UNC][SDB] && !i_unc_err[SDB] && !i_cfg_wr)
    |=> !sts_r[UNC][SDB])
    else $error("surprise down logged with power control set");

  a_sdown_logged: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_surprise_down && !slot_ctrl_r[PWRB] && !mask_r[UNC][SDB]) |=> sts_r[UNC][SDB])
    else $error("surprise down not logged");

  // An unmasked malformed packet sets its flag and freezes the header until the flag is cleared.
  a_mal_flagged: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_malformed_tlp && !mask_r[UNC][MALB]) |=> sts_r[UNC][MALB])
    else $error("malformed packet not flagged");

  a_hdr_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    mal_capture |=> sts_r[UNC][MALB] && (hdr_r == $past(i_tlp_header)))
    else $error("malformed header not captured");

  a_hdr_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !mal_capture |=> $stable(hdr_r))
    else $error("header changed without a capture");

  a_w1c_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> (($past(sts_r[PUNC]) & ~sts_r[PUNC] & ~$past(w1c[PUNC])) == '0))
    else $error("status bit lost without write one");

  a_slot_store: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cfg_wr && slot_hit) |=> (slot_ctrl_r == 16'($past(i_cfg_wdata))))
    else $error("slot control write not stored");

  a_pwr_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_pwr_ctrl == $past(slot_ctrl_r[PWRB])))
    else $error("power control output does not follow slot control");

  // The report output trails the pending set by one register stage.
  a_report_up: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (pend_any != '0) |=> o_err_report)
    else $error("pending error not reported");

  a_report_down: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (pend_any == '0) |=> !o_err_report)
    else $error("report raised with nothing pending");

  // Every access is acknowledged one cycle later; read data is zero outside a read.
  a_read_ack: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cfg_rd |=> o_cfg_ack)
    else $error("read not acknowledged");

  a_write_ack: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cfg_wr |=> o_cfg_ack)
    else $error("write not acknowledged");

  a_idle_no_ack: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_cfg_rd && !i_cfg_wr) |=> !o_cfg_ack)
    else $error("acknowledge without an access");

  a_idle_rdata_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_cfg_rd |=> (o_cfg_rdata == '0))
    else $error("read data not zero outside a read");

  a_unmapped_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cfg_rd && !slot_hit && !hdr_hit && (sts_hit == '0) && (mask_hit == '0))
    |=> (o_cfg_rdata == '0))
    else $error("unmapped read not zero");

  a_read_slot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cfg_rd && slot_hit) |=> (o_cfg_rdata == {16'h0000, $past(slot_ctrl_r)}))
    else $error("slot control read back wrong");

  a_read_hdr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cfg_rd && hdr_hit) |=> (o_cfg_rdata == $past(hdr_r)))
    else $error("header read back wrong");

  // Per pair: recording, clearing, mask storage and read-back.
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pair_chk
      a_event_sets: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (ev_kept[p] != '0) |=> ((sts_r[p] & $past(ev_kept[p])) == $past(ev_kept[p])))
        else $error("unmasked event not recorded");

      a_w1c_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> (($past(sts_r[p]) & ~sts_r[p] & ~$past(w1c[p])) == '0))
        else $error("status bit lost without write one");

      a_w1c_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (w1c[p] != '0) |=> ((sts_r[p] & $past(w1c[p]) & ~$past(ev_kept[p])) == '0))
        else $error("status bit not cleared by write one");

      a_mask_store: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_wr && mask_hit[p]) |=> (mask_r[p] == $past(i_cfg_wdata)))
        else $error("mask write not stored");

      a_mask_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(i_cfg_wr && mask_hit[p]) |=> $stable(mask_r[p]))
        else $error("mask changed without a write");

      a_read_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_rd && sts_hit[p]) |=> (o_cfg_rdata == $past(sts_r[p])))
        else $error("status read back wrong");

      a_read_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_rd && mask_hit[p]) |=> (o_cfg_rdata == $past(mask_r[p])))
        else $error("mask read back wrong");
    end
  endgenerate

  c_mask_cleared: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cfg_wr && mask_hit[UNC] && (i_cfg_wdata == '0));
  c_sdown_logged: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sdown_ok && !mask_r[UNC][SDB]);
  c_hdr_captured: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) mal_capture);
  c_report_up: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_err_report));
  c_status_cleared: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (w1c[UNC] & sts_r[UNC]) != '0);
endmodule // rpel_root_port_err
`default_nettype wire

// ### testbench/rpel_ep_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpel_ep_model (
  input  wire logic   i_ref_clk,
  output logic [31:0] o_err [5],
  output logic        o_sd,
  output logic        o_mal,
  output logic [31:0] o_hdr
);
  initial begin
    o_err = '{default: 32'h0000_0000};
    o_sd = 1'b0;
    o_mal = 1'b0;
    o_hdr = 32'h0000_0000;
  end
  // Raises one event for one cycle; an unsampled header shows its inverse.
  task automatic fire(input int k, input logic [31:0] v);
    @(negedge i_ref_clk);
    if (k < 5) o_err[k] = v;
    o_sd = (k == 5);
    o_mal = (k == 6);
    o_hdr = v;
    @(negedge i_ref_clk);
    if (k < 5) o_err[k] = 32'h0000_0000;
    o_sd = 1'b0;
    o_mal = 1'b0;
    o_hdr = ~v;
  endtask
endmodule // rpel_ep_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        ack;
  logic        rep;
  logic        pwr;
  logic [31:0] err [5];
  logic        sd;
  logic        mal;
  logic [31:0] hdr;
  int          miscompares = 0;
  int          n_compared = 0;
  always #20 clk = ~clk;
  rpel_ep_model i_ep (.i_ref_clk(clk), .o_err(err), .o_sd(sd), .o_mal(mal), .o_hdr(hdr));
  rpel_root_port_err i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cfg_addr(addr),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_ack(ack), .i_unc_err(err[0]), .i_cor_err(err[1]), .i_root_err(err[2]),
    .i_port_cor_err(err[3]), .i_port_unc_err(err[4]), .i_surprise_down(sd),
    .i_malformed_tlp(mal), .i_tlp_header(hdr), .o_err_report(rep), .o_pwr_ctrl(pwr));
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    `CHK(ack, 1'b1)
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(rdata, e)
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 5; k++) begin
      rchk(rpel_pkg::OFS_MASK[k], 32'hffff_ffff);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_0000);
    end
    rchk(rpel_pkg::OFS_SLOT_CTRL, 32'h0000_0400);
    rchk(12'h0fc, 32'h0000_0000);
    `CHK(pwr, 1'b1)
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      i_ep.fire(k, 32'hffff_ffff);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_0000);
    end
    `CHK(rep, 1'b0)
    $display("test masked done");
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, rpel_pkg::OFS_MASK[k], 32'hffff_0000);
      i_ep.fire(k, 32'hffff_ffff);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_ffff);
      `CHK(rep, 1'b1)
      acc(1'b1, rpel_pkg::OFS_STS[k], 32'h0000_0000);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_ffff);
      acc(1'b1, rpel_pkg::OFS_STS[k], 32'h0000_00ff);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_ff00);
      acc(1'b1, rpel_pkg::OFS_STS[k], 32'hffff_ffff);
      acc(1'b1, rpel_pkg::OFS_MASK[k], 32'h0000_0000);
      rchk(rpel_pkg::OFS_STS[k], 32'h0000_0000);
    end
    `CHK(rep, 1'b0)
    $display("test pairs done");
    i_ep.fire(5, 32'h0000_0000);
    rchk(rpel_pkg::OFS_STS[0], 32'h0000_0000);
    acc(1'b1, rpel_pkg::OFS_SLOT_CTRL, 32'h0000_0000);
    @(negedge clk);
    `CHK(pwr, 1'b0)
    i_ep.fire(5, 32'h0000_0000);
    rchk(rpel_pkg::OFS_STS[0], 32'h0000_0020);
    acc(1'b1, rpel_pkg::OFS_STS[0], 32'h0000_0020);
    i_ep.fire(6, 32'h5a5a_c3c3);
    rchk(rpel_pkg::OFS_STS[0], 32'h0004_0000);
    rchk(rpel_pkg::OFS_HDR_CAP, 32'h5a5a_c3c3);
    $display("test events done");
    complete_run();
  end
  initial begin
    #50000;
    miscompares++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
